// >>> pkg/tpw_pkg.sv
/*
 Constants, register map and carrier types of the timer PWM block.
 Assumes a 32-bit Avalon-MM bus with byte addresses and one clock.
*/
package tpw_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL1      = 8'h00;
   localparam logic [7:0] OFS_CTRL2      = 8'h04;
   localparam logic [7:0] OFS_STATUS     = 8'h08;
   localparam logic [7:0] OFS_PULSE_HI   = 8'h0C;
   localparam logic [7:0] OFS_PULSE_LO   = 8'h10;
   localparam logic [7:0] OFS_PERIOD_HI  = 8'h14;
   localparam logic [7:0] OFS_PERIOD_LO  = 8'h18;
   localparam logic [7:0] OFS_COUNT      = 8'h1C;
   localparam logic [7:0] OFS_CAPTURE2   = 8'h20;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int ST_CAP1 = 7;
   localparam int ST_CMP1 = 6;
   localparam int ST_OVF  = 5;
   localparam int ST_CAP2 = 4;
   localparam int ST_CMP2 = 3;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [15:0] CNT_RESET    = 16'hFFFC;
   localparam logic [15:0] CNT_RELOAD   = 16'hFFFC;
   localparam logic [15:0] CNT_TOP      = 16'hFFFF;
   localparam logic [15:0] CMP_RESET    = 16'h8000;
   localparam logic [1:0]  CLK_DIV4     = 2'h0;
   localparam logic [1:0]  CLK_DIV2     = 2'h1;
   localparam logic [1:0]  CLK_DIV8     = 2'h2;
   localparam logic [1:0]  CLK_EXT      = 2'h3;
   localparam logic [2:0]  PRE_LAST_D4  = 3'h3;
   localparam logic [2:0]  PRE_LAST_D2  = 3'h1;
   localparam logic [2:0]  PRE_LAST_D8  = 3'h7;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       capture_irq_en;
      logic       compare_irq_en;
      logic       overflow_irq_en;
      logic       level_after_cmp2;
      logic       cap1_edge;
      logic       level_after_cmp1;
      logic       wave_pin_enable;
      logic       single_pulse_select;
      logic       pwm_select;
      logic [1:0] clock_select_field;
      logic       cap2_edge;
      logic       ext_edge;
   } tpw_ctrl_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HALT = 2'b10
   } tpw_state_t;

endpackage

// >>> logic/tpw_sync.sv
/*
 Multi-bit two-stage synchroniser for pin inputs.
 Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
module tpw_sync #(
   parameter int WIDTH  = 3,
   parameter int STAGES = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_reg [STAGES];

   generate
      if (STAGES < 2 || WIDTH < 1)
      begin : g_bad
         $error("tpw_sync needs at least two stages and one bit");
      end
   endgenerate

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int i = 0; i < STAGES; i++)
            stage_reg[i] <= '0;
      end
      else
      begin
         stage_reg[0] <= async_in;
         for (int i = 1; i < STAGES; i++)
            stage_reg[i] <= stage_reg[i-1];
      end
   end

   assign sync_out = stage_reg[STAGES-1];
endmodule

// >>> logic/tpw_cmp_buf.sv
/*
 One double-buffered 16-bit compare register written as two bytes.
 Assumes byte strobes are single-cycle and never both high together.
*/
`timescale 1ns/1ps
module tpw_cmp_buf (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wr_hi,
   input  wire logic        wr_lo,
   input  wire logic [7:0]  wr_byte,
   input  wire logic        pwm_mode,
   input  wire logic        reload,
   output logic      [15:0] shadow,
   output logic      [15:0] active,
   output logic             inhibit
);
   logic [15:0] shadow_reg;
   logic [15:0] active_reg;
   logic        inhibit_reg;

   // ------------------------------------------------------------
   // Written value
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         shadow_reg <= tpw_pkg::CMP_RESET;
      else if (wr_hi)
         shadow_reg[15:8] <= wr_byte;
      else if (wr_lo)
         shadow_reg[7:0] <= wr_byte;
   end

   // High byte blocks compare until low byte follows
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         inhibit_reg <= 1'b0;
      else if (wr_hi)
         inhibit_reg <= 1'b1;
      else if (wr_lo)
         inhibit_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // Active copy: follows at once, or only at period end in PWM
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         active_reg <= tpw_pkg::CMP_RESET;
      else if (!pwm_mode || reload)
         active_reg <= shadow_reg;
   end

   assign shadow  = shadow_reg;
   assign active  = active_reg;
   assign inhibit = inhibit_reg;
endmodule

// >>> logic/tpw_top.sv
/*
 PWM mode of a 16-bit free-running timer with flags and low-power handling.
 Assumes an Avalon-MM master on clk_sys and same-domain mask/wait/halt levels.
*/
// How it works
// - Compare values are double-buffered; in PWM mode new writes apply only at period end, otherwise at once.
// - Pulse match drives level one, period match drives level two onto pin.
// - Levels one/zero give a high pulse of period minus pulse compare.
// - Equal levels hold the pin constant while PWM mode runs.
// - Period match reloads the counter with FFFCh to start next period.
// - High-byte write suppresses that compare until its low byte is written.
// - Compare flags never set in PWM mode.
// - Period match sets capture-one flag; interrupt if enabled and unmasked.
// - Capture pin one disconnected in PWM; pin two still captures.
// - PWM select overrides single-pulse select.
// - PWM uses compare one and period register; compare two unavailable.
// - Wait mode leaves timer running; enabled interrupts wake the core.
// - Halt freezes counter and registers; reset restarts from reset value.
// - All events share one request, each gated by enable and global mask.
// - Capture, compare, overflow flags map to their three enables.
// - Clock select 00 divides by 4, 01 by 2, 10 by 8, 11 external.
// - PWM select makes the pin a cyclic signal set by both compares.
`timescale 1ns/1ps
module tpw_top (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        ext_clk_pin,
   input  wire logic        capture_pin_1,
   input  wire logic        capture_pin_2,
   input  wire logic        int_mask,
   input  wire logic        wait_mode,
   input  wire logic        halt_mode,
   output logic             wave_out_pin_1,
   output logic             wave_pin_active,
   output logic             timer_irq,
   output logic             wait_wake
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0]         ctrl1_reg;
   logic [7:0]         ctrl2_reg;
   tpw_pkg::tpw_ctrl_t ctrl;
   tpw_pkg::tpw_state_t state_reg;
   logic [31:0] rd_next;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic        done;
   logic        wr_ok;
   logic        lo1_access;
   logic        lo2_access;
   logic [2:0]  pin_sync;
   logic [2:0]  pin_prev_reg;
   logic        ext_tick;
   logic        cap1_edge_evt;
   logic        cap2_edge_evt;
   logic [2:0]  pre_cnt_reg;
   logic [2:0]  pre_last;
   logic        tick;
   logic [15:0] cnt_reg;
   logic        st_run;
   logic        st_pwm;
   logic        halt_exit;
   logic [15:0] pulse_shadow;
   logic [15:0] pulse_act;
   logic        pulse_inh;
   logic [15:0] period_shadow;
   logic [15:0] period_act;
   logic        period_inh;
   logic        pulse_hit;
   logic        per_hit;
   logic        reload;
   logic        cap1_flag_reg;
   logic        cap2_flag_reg;
   logic        cmp1_flag_reg;
   logic        cmp2_flag_reg;
   logic        ovf_flag_reg;
   logic        arm1_reg;
   logic        arm2_reg;
   logic [15:0] capture2_reg;
   logic        wave_reg;
   logic        pin_en_reg;
   logic        irq_reg;
   logic        wake_reg;
   logic        irq_req;
   logic [7:0]  status;

   assign ctrl = {ctrl1_reg[7:5], ctrl1_reg[2:0], ctrl2_reg[7], ctrl2_reg[5:0]};

   // ------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then completion edge
   // ------------------------------------------------------------
   assign done  = (avs_read || avs_write) && !wait_reg;
   assign wr_ok = done && avs_write && avs_byteenable[0];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         wait_reg <= 1'b1;
      else if ((avs_read || avs_write) && wait_reg)
         wait_reg <= 1'b0;
      else
         wait_reg <= 1'b1;
   end

   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (avs_address & 8'hFC)
         tpw_pkg::OFS_CTRL1:     rd_next[7:0] = ctrl1_reg;
         tpw_pkg::OFS_CTRL2:     rd_next[7:0] = ctrl2_reg;
         tpw_pkg::OFS_STATUS:    rd_next[7:0] = status;
         tpw_pkg::OFS_PULSE_HI:  rd_next[7:0] = pulse_shadow[15:8];
         tpw_pkg::OFS_PULSE_LO:  rd_next[7:0] = pulse_shadow[7:0];
         tpw_pkg::OFS_PERIOD_HI: rd_next[7:0] = period_shadow[15:8];
         tpw_pkg::OFS_PERIOD_LO: rd_next[7:0] = period_shadow[7:0];
         tpw_pkg::OFS_COUNT:     rd_next[15:0] = cnt_reg;
         tpw_pkg::OFS_CAPTURE2:  rd_next[15:0] = capture2_reg;
         default:                rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rdata_reg <= 32'h0000_0000;
      else if (avs_read && wait_reg)
         rdata_reg <= rd_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl1_reg <= tpw_pkg::CTRL_RESET;
         ctrl2_reg <= tpw_pkg::CTRL_RESET;
      end
      else if (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_CTRL1)
         ctrl1_reg <= avs_writedata[7:0];
      else if (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_CTRL2)
         ctrl2_reg <= avs_writedata[7:0];
   end

   assign lo1_access = done && (avs_address & 8'hFC) == tpw_pkg::OFS_PULSE_LO;
   assign lo2_access = done && (avs_address & 8'hFC) == tpw_pkg::OFS_PERIOD_LO;

   // ------------------------------------------------------------
   // Compare registers
   // ------------------------------------------------------------
   tpw_cmp_buf u_pulse (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .wr_hi    (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_PULSE_HI),
      .wr_lo    (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_PULSE_LO),
      .wr_byte  (avs_writedata[7:0]),
      .pwm_mode (st_pwm),
      .reload   (reload),
      .shadow   (pulse_shadow),
      .active   (pulse_act),
      .inhibit  (pulse_inh)
   );

   tpw_cmp_buf u_period (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .wr_hi    (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_PERIOD_HI),
      .wr_lo    (wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_PERIOD_LO),
      .wr_byte  (avs_writedata[7:0]),
      .pwm_mode (st_pwm),
      .reload   (reload),
      .shadow   (period_shadow),
      .active   (period_act),
      .inhibit  (period_inh)
   );

   // ------------------------------------------------------------
   // Pins and timer clock
   // ------------------------------------------------------------
   tpw_sync #(.WIDTH(3), .STAGES(2)) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in ({capture_pin_2, capture_pin_1, ext_clk_pin}),
      .sync_out (pin_sync)
   );

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         pin_prev_reg <= 3'h0;
      else
         pin_prev_reg <= pin_sync;
   end

   assign ext_tick = ctrl.ext_edge ? (pin_sync[0] && !pin_prev_reg[0])
                                   : (!pin_sync[0] && pin_prev_reg[0]);
   assign cap1_edge_evt = ctrl.cap1_edge ? (pin_sync[1] && !pin_prev_reg[1])
                                         : (!pin_sync[1] && pin_prev_reg[1]);
   assign cap2_edge_evt = ctrl.cap2_edge ? (pin_sync[2] && !pin_prev_reg[2])
                                         : (!pin_sync[2] && pin_prev_reg[2]);

   always_comb
   begin
      case (ctrl.clock_select_field)
         tpw_pkg::CLK_DIV4: pre_last = tpw_pkg::PRE_LAST_D4;
         tpw_pkg::CLK_DIV2: pre_last = tpw_pkg::PRE_LAST_D2;
         tpw_pkg::CLK_DIV8: pre_last = tpw_pkg::PRE_LAST_D8;
         default:           pre_last = tpw_pkg::PRE_LAST_D8;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst || (st_run && pre_cnt_reg == pre_last))
         pre_cnt_reg <= 3'h0;
      else if (st_run)
         pre_cnt_reg <= pre_cnt_reg + 3'h1;
   end

   assign tick = st_run && ((ctrl.clock_select_field == tpw_pkg::CLK_EXT) ? ext_tick
                            : (pre_cnt_reg == pre_last));

   // ------------------------------------------------------------
   // Run/halt state and counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state_reg <= tpw_pkg::ST_RUN;
      else
      begin
         case (state_reg)
            tpw_pkg::ST_RUN:  if (halt_mode) state_reg <= tpw_pkg::ST_HALT;
            tpw_pkg::ST_HALT: if (!halt_mode) state_reg <= tpw_pkg::ST_RUN;
            default:          state_reg <= tpw_pkg::ST_RUN;
         endcase
      end
   end

   assign st_run    = state_reg == tpw_pkg::ST_RUN;
   assign halt_exit = state_reg == tpw_pkg::ST_HALT && !halt_mode;
   assign st_pwm    = ctrl.pwm_select;
   assign pulse_hit = tick && cnt_reg == pulse_act && !pulse_inh;
   assign per_hit   = tick && cnt_reg == period_act && !period_inh;
   assign reload    = st_pwm && per_hit;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cnt_reg <= tpw_pkg::CNT_RESET;
      else if (reload)
         cnt_reg <= tpw_pkg::CNT_RELOAD;
      else if (tick)
         cnt_reg <= cnt_reg + 16'h0001;
   end

   // ------------------------------------------------------------
   // Flags, set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         arm1_reg <= 1'b0;
         arm2_reg <= 1'b0;
      end
      else if (halt_exit)
      begin
         arm1_reg <= 1'b0;
         arm2_reg <= 1'b0;
      end
      else if (!st_run)
      begin
         arm1_reg <= arm1_reg || (cap1_edge_evt && !st_pwm);
         arm2_reg <= arm2_reg || cap2_edge_evt;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cap1_flag_reg <= 1'b0;
         cap2_flag_reg <= 1'b0;
         cmp1_flag_reg <= 1'b0;
         cmp2_flag_reg <= 1'b0;
         ovf_flag_reg  <= 1'b0;
      end
      else
      begin
         cap1_flag_reg <= reload || (st_run && !st_pwm && cap1_edge_evt)
                          || (halt_exit && arm1_reg)
                          || (cap1_flag_reg && !(wr_ok && (avs_address & 8'hFC)
                              == tpw_pkg::OFS_STATUS && avs_writedata[tpw_pkg::ST_CAP1]));
         cap2_flag_reg <= (st_run && cap2_edge_evt) || (halt_exit && arm2_reg)
                          || (cap2_flag_reg && !(wr_ok && (avs_address & 8'hFC)
                              == tpw_pkg::OFS_STATUS && avs_writedata[tpw_pkg::ST_CAP2]));
         cmp1_flag_reg <= (!st_pwm && pulse_hit) || (cmp1_flag_reg && !lo1_access
                          && !(wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_STATUS
                          && avs_writedata[tpw_pkg::ST_CMP1]));
         cmp2_flag_reg <= (!st_pwm && per_hit) || (cmp2_flag_reg && !lo2_access
                          && !(wr_ok && (avs_address & 8'hFC) == tpw_pkg::OFS_STATUS
                          && avs_writedata[tpw_pkg::ST_CMP2]));
         ovf_flag_reg  <= (tick && !reload && cnt_reg == tpw_pkg::CNT_TOP)
                          || (ovf_flag_reg && !(wr_ok && (avs_address & 8'hFC)
                              == tpw_pkg::OFS_STATUS && avs_writedata[tpw_pkg::ST_OVF]));
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         capture2_reg <= 16'h0000;
      else if (halt_exit && arm2_reg)
         capture2_reg <= cnt_reg;
      else if (st_run && cap2_edge_evt)
         capture2_reg <= cnt_reg;
   end

   always_comb
   begin
      status                = 8'h00;
      status[tpw_pkg::ST_CAP1] = cap1_flag_reg;
      status[tpw_pkg::ST_CMP1] = cmp1_flag_reg;
      status[tpw_pkg::ST_OVF]  = ovf_flag_reg;
      status[tpw_pkg::ST_CAP2] = cap2_flag_reg;
      status[tpw_pkg::ST_CMP2] = cmp2_flag_reg;
   end

   // ------------------------------------------------------------
   // Waveform pin
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         wave_reg <= 1'b0;
      else if (!ctrl.wave_pin_enable)
         wave_reg <= wave_reg;
      else if (st_pwm && ctrl.level_after_cmp1 == ctrl.level_after_cmp2)
         wave_reg <= ctrl.level_after_cmp1;
      else if (st_pwm && per_hit)
         wave_reg <= ctrl.level_after_cmp2;
      else if (pulse_hit)
         wave_reg <= ctrl.level_after_cmp1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         pin_en_reg <= 1'b0;
      else
         pin_en_reg <= ctrl.wave_pin_enable;
   end

   // ------------------------------------------------------------
   // Interrupt request and wait wake-up
   // ------------------------------------------------------------
   assign irq_req = (ctrl.capture_irq_en && (cap1_flag_reg || cap2_flag_reg))
                    || (ctrl.compare_irq_en && (cmp1_flag_reg || cmp2_flag_reg))
                    || (ctrl.overflow_irq_en && ovf_flag_reg);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         irq_reg  <= irq_req && !int_mask;
         wake_reg <= irq_req && !int_mask && wait_mode;
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign wave_out_pin_1  = wave_reg;
   assign wave_pin_active = pin_en_reg;
   assign timer_irq       = irq_reg;
   assign wait_wake       = wake_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   pwm_no_cmp_a: assert property (st_pwm |=> !$rose(cmp1_flag_reg) && !$rose(cmp2_flag_reg))
      else $error("compare flag set in PWM mode");
   period_reload_a: assert property (reload |=> cnt_reg == 16'hFFFC)
      else $error("counter not reloaded at period end");
   buf_load_a: assert property (reload |=> pulse_act == $past(pulse_shadow))
      else $error("pulse copy not loaded at reload");
   buf_hold_a: assert property (st_pwm && !reload |=> $stable(period_act))
      else $error("period copy changed mid period");
   pin_pulse_a: assert property (st_pwm && pulse_hit && !per_hit && ctrl.wave_pin_enable
      |=> wave_reg == $past(ctrl.level_after_cmp1))
      else $error("pin not at level one after pulse match");
   cap1_set_a: assert property (reload |=> cap1_flag_reg)
      else $error("capture one flag missing at period end");
   halt_freeze_a: assert property (!st_run |=> cnt_reg == $past(cnt_reg))
      else $error("counter moved in halt");
   irq_gate_a: assert property (int_mask |=> !timer_irq)
      else $error("interrupt raised while masked");
   inhibit_a: assert property (pulse_inh && !per_hit && !(st_pwm
      && ctrl.level_after_cmp1 == ctrl.level_after_cmp2) |=> $stable(wave_reg))
      else $error("compare fired while inhibited");
   const_level_a: assert property (st_pwm && ctrl.wave_pin_enable
      && ctrl.level_after_cmp1 == ctrl.level_after_cmp2 ##1 st_pwm
      |-> wave_reg == $past(ctrl.level_after_cmp1))
      else $error("pin not constant with equal levels");
endmodule

// >>> tb/tpw_load.sv
/*
 Load on the waveform pin: measures high time, period and edge count.
 Assumes the pin is sampled on clk_sys rising edges.
*/
`timescale 1ns/1ps
module tpw_load (
   input  wire logic clk_sys,
   input  wire logic wave_in,
   output int        high_len,
   output int        period_len,
   output int        edges
);
   int   hi_cnt = 0;
   int   per_cnt = 0;
   logic last = 1'b0;
   initial
   begin
      high_len = 0;
      period_len = 0;
      edges = 0;
   end
   always @(posedge clk_sys)
   begin
      per_cnt++;
      if (wave_in === 1'b1) hi_cnt++;
      if (wave_in !== last) edges++;
      if (wave_in === 1'b1 && last !== 1'b1)
      begin
         period_len = per_cnt;
         per_cnt = 0;
      end
      if (wave_in !== 1'b1 && last === 1'b1)
      begin
         high_len = hi_cnt;
         hi_cnt = 0;
      end
      last = wave_in;
   end
endmodule

// >>> tb/testbench.sv
/*
 Self-checking bench for the timer PWM block.
 Assumes the load model and the block under test on one 25 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
   logic        clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0;
   logic [7:0]  avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic        avs_waitrequest, int_mask = 0, wait_mode = 0, halt_mode = 0, cap_pin = 0;
   logic        wave_out_pin_1, wave_pin_active, timer_irq, wait_wake;
   int          failures = 0, total_checks = 0, hl, pl, ed, e0;
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end
   tpw_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_clk_pin(1'b0), .capture_pin_1(cap_pin),
      .capture_pin_2(cap_pin), .int_mask(int_mask), .wait_mode(wait_mode),
      .halt_mode(halt_mode), .wave_out_pin_1(wave_out_pin_1),
      .wave_pin_active(wave_pin_active), .timer_irq(timer_irq), .wait_wake(wait_wake));
   tpw_load LOAD (.clk_sys(clk_sys), .wave_in(wave_out_pin_1), .high_len(hl),
      .period_len(pl), .edges(ed));
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do
      begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (e !== g)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_pwm;
      bus(1, tpw_pkg::OFS_PERIOD_HI, 32'h0000_0000);
      bus(1, tpw_pkg::OFS_PERIOD_LO, 32'h0000_0006);
      bus(1, tpw_pkg::OFS_PULSE_HI, 32'h0000_0000);
      bus(1, tpw_pkg::OFS_PULSE_LO, 32'h0000_0002);
      bus(1, tpw_pkg::OFS_CTRL1, 32'h0000_0081);
      bus(1, tpw_pkg::OFS_CTRL2, 32'h0000_00B0);
      repeat (200) @(posedge clk_sys);
      chk("high_len", 32'd16, hl);
      chk("period_len", 32'd44, pl);
      chk("pin_active", 1, wave_pin_active);
      bus(1, tpw_pkg::OFS_PULSE_HI, 32'h0000_0000);
      bus(1, tpw_pkg::OFS_PULSE_LO, 32'h0000_0004);
      repeat (150) @(posedge clk_sys);
      chk("new_high_len", 32'd8, hl);
      bus(1, tpw_pkg::OFS_CTRL2, 32'h0000_00B4);
      repeat (150) @(posedge clk_sys);
      chk("div2_period", 32'd22, pl);
      chk("div2_high", 32'd4, hl);
      bus(0, tpw_pkg::OFS_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_0080, rd & 32'h0000_00C8);
   endtask
   task t_irq;
      wait_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("irq", 1, timer_irq);
      chk("wake", 1, wait_wake);
      int_mask <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("irq_masked", 0, timer_irq);
      int_mask <= 1'b0;
      wait_mode <= 1'b0;
   endtask
   task t_halt;
      logic [31:0] c0;
      halt_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      bus(0, tpw_pkg::OFS_COUNT, 32'h0000_0000);
      c0 = rd;
      cap_pin <= 1'b1;
      repeat (20) @(posedge clk_sys);
      cap_pin <= 1'b0;
      repeat (20) @(posedge clk_sys);
      bus(0, tpw_pkg::OFS_COUNT, 32'h0000_0000);
      chk("halt_count", c0, rd);
      halt_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus(0, tpw_pkg::OFS_CAPTURE2, 32'h0000_0000);
      chk("capture2", c0, rd);
      bus(0, tpw_pkg::OFS_STATUS, 32'h0000_0000);
      chk("cap2_flag", 32'h0000_0010, rd & 32'h0000_0010);
   endtask
   task t_equal;
      bus(1, tpw_pkg::OFS_CTRL1, 32'h0000_0005);
      repeat (100) @(posedge clk_sys);
      e0 = ed;
      repeat (200) @(posedge clk_sys);
      chk("edges", e0, ed);
      chk("level", 1, wave_out_pin_1);
   endtask
   initial
   begin
      #(40 * 20000);
      failures++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_pwm();
      t_irq();
      t_halt();
      t_equal();
      report_and_stop();
   end
endmodule
